// [hw/adc_sample_sequencer_control.sv]
// What this block does
// - Four sequencers: 8, 4, 4, 1 steps.
// - Result word 32 bits, value low ten.
// - Step has input nibble, control nibble.
// - Sequencer starts only while active flag set; a started sequence runs to its end.
// - Steps run back to back unattended.
// - Repeated inputs in one sequence allowed.
// - Per-step interrupt flag raises raw interrupt.
// - Sequence ends at step with last marker.
// - Result queue circular; read pops oldest.
// - Queue status shows head, tail, full, empty.
// - Overflow and underflow flags per sequencer.
// - Converter paced near 16.667 MHz enable.
// - Mask gates raw interrupts to output.
// - Raw and masked interrupt views readable.
// - Write one to masked view clears.
// - Concurrent triggers served by priority value.
// - Trigger source selected per sequencer.
// - Software trigger bit starts sequencer.
// - Shared averager up to 64 conversions.
// - Averager disabled after reset.
// - Reset priority: zero highest, three lowest.
`default_nettype none
module adc_sample_sequencer_control
  import seq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               srst,
  // Avalon-MM slave
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output var  logic [31:0]        avs_readdata,
  output var  logic               avs_waitrequest,
  // External trigger pins, one per sequencer
  input  wire logic [3:0]         ext_trigger,
  // Converter core
  output var  logic               conv_start,
  output var  conv_req_t          conv_req,
  input  wire logic               conv_done,
  input  wire logic [RES_W-1:0]   conv_result,
  // Masked interrupt lines
  output var  logic [3:0]         seq_irq
);

  localparam logic [3:0] DEPTH_LAST [NUM_SEQ] = '{4'h7, 4'h3, 4'h3, 4'h0};

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0]        active_seq_r;
  logic [3:0]        irq_gate_r;
  logic [3:0]        raw_irq_r;
  logic [3:0]        overflow_r;
  logic [3:0]        underflow_r;
  logic [15:0]       trigger_sel_r;
  logic [15:0]       priority_r;
  logic [2:0]        avg_r;
  logic [3:0]        pending_r;
  logic [31:0]       input_sel_r [NUM_SEQ];
  logic [31:0]       step_ctl_r  [NUM_SEQ];
  logic [RES_W-1:0]  queue_r [NUM_SEQ][MAX_STEPS];
  logic [PTR_W-1:0]  head_r [NUM_SEQ];
  logic [PTR_W-1:0]  tail_r [NUM_SEQ];
  logic [CNT_W-1:0]  count_r [NUM_SEQ];
  logic [3:0]        ext_m_r, ext_s_r, ext_d_r;
  logic [4:0]        div_r;
  logic              tick_r;
  run_state_t        state_r;
  logic [1:0]        cur_r;
  logic [2:0]        step_r;
  logic [6:0]        avg_cnt_r;
  logic [16:0]       acc_r;
  logic              ack_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [5:0] idx;
  logic       req;
  logic       in_seq;
  logic [1:0] win_seq;
  logic [2:0] win_sub;
  logic       wr_acc, rd_acc;
  assign idx     = avs_address[7:2];
  assign req     = (avs_read | avs_write) & ~ack_r;
  assign wr_acc  = avs_write & ~ack_r;
  assign rd_acc  = avs_read & ~ack_r;
  assign in_seq  = idx >= SEQ_BASE_IDX;
  assign win_seq = 2'((idx - SEQ_BASE_IDX) >> 3);
  assign win_sub = idx[2:0];

  // One wait state: every access answers on the second edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_r           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_r           <= req;
      avs_waitrequest <= ~req;
    end
  end

  // ----------------------------------------------------------------
  // Trigger synchronisers and converter pace divider
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_m_r <= 4'h0;
      ext_s_r <= 4'h0;
      ext_d_r <= 4'h0;
    end else begin
      ext_m_r <= ext_trigger;
      ext_s_r <= ext_m_r;
      ext_d_r <= ext_s_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_r  <= 5'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == CONV_DIV_LAST);
      div_r  <= (div_r == CONV_DIV_LAST) ? 5'h0 : div_r + 5'h1;
    end
  end

  // ----------------------------------------------------------------
  // Trigger latching and arbitration
  // ----------------------------------------------------------------
  logic [3:0] trig_now;
  logic [3:0] eligible;
  logic [1:0] win_idx;
  logic       win_any;
  logic       start;
  logic       seq_done;

  genvar g;
  generate
    for (g = 0; g < NUM_SEQ; g++) begin : g_trig
      always_comb begin
        unique case (trigger_sel_r[4*g +: 4])
          TRIG_PROCESSOR: trig_now[g] = wr_acc && idx == SW_TRIG_IDX && avs_writedata[g];
          TRIG_EXTERNAL:  trig_now[g] = ext_s_r[g] & ~ext_d_r[g];
          TRIG_ALWAYS:    trig_now[g] = 1'b1;
          default:        trig_now[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // only active sequencers latch and start; a started sequence runs to its end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pending_r <= 4'h0;
    end else begin
      for (int i = 0; i < NUM_SEQ; i++) begin
        if (start && win_idx == 2'(i)) begin
          pending_r[i] <= 1'b0;
        end
        if (trig_now[i] && active_seq_r[i]) begin
          pending_r[i] <= 1'b1;
        end
        if (!active_seq_r[i]) begin
          pending_r[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    logic [1:0] best;
    best     = 2'h3;
    win_idx  = 2'h0;
    win_any  = 1'b0;
    eligible = pending_r & active_seq_r;
    for (int i = 0; i < NUM_SEQ; i++) begin
      if (eligible[i] && (!win_any || priority_r[4*i +: 2] < best)) begin
        best    = priority_r[4*i +: 2];
        win_idx = 2'(i);
        win_any = 1'b1;
      end
    end
  end
  assign start = (state_r == ST_IDLE) && win_any;

  // ----------------------------------------------------------------
  // Step sequencing
  // ----------------------------------------------------------------
  logic [3:0] cur_ctl;
  logic [3:0] cur_inp;
  logic       grp_done;
  logic       is_last;
  logic [6:0] avg_n;
  logic [16:0] acc_sum;
  logic [RES_W-1:0] avg_val;
  logic       push;

  assign cur_ctl  = step_ctl_r[cur_r][4*step_r +: 4];
  assign cur_inp  = input_sel_r[cur_r][4*step_r +: 4];
  assign avg_n    = 7'h1 << avg_r;
  assign acc_sum  = acc_r + 17'(conv_result);
  // shared averager, divide by power of two
  assign avg_val  = RES_W'(acc_sum >> avg_r);
  assign grp_done = (state_r == ST_WAIT) && conv_done && (avg_cnt_r + 7'h1 == avg_n);
  // last marker or last physical step ends
  assign is_last  = cur_ctl[CTL_LAST] || (4'(step_r) == DEPTH_LAST[cur_r]);
  assign push     = grp_done;
  assign seq_done = grp_done && is_last;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r   <= ST_IDLE;
      cur_r     <= 2'h0;
      step_r    <= 3'h0;
      avg_cnt_r <= 7'h0;
      acc_r     <= 17'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (win_any) begin
            cur_r   <= win_idx;
            step_r  <= 3'h0;
            state_r <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (tick_r) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (conv_done) begin
            if (grp_done) begin
              avg_cnt_r <= 7'h0;
              acc_r     <= 17'h0;
              if (is_last) begin
                state_r <= ST_IDLE;
              end else begin
                step_r  <= step_r + 3'h1;
                state_r <= ST_REQ;
              end
            end else begin
              avg_cnt_r <= avg_cnt_r + 7'h1;
              acc_r     <= acc_sum;
              state_r   <= ST_REQ;
            end
          end
        end
      endcase
    end
  end

  // any input code per step, repeats allowed
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_start <= 1'b0;
      conv_req   <= '0;
    end else begin
      conv_start <= (state_r == ST_REQ) && tick_r;
      if ((state_r == ST_REQ) && tick_r) begin
        conv_req.diff      <= cur_ctl[CTL_DIFF];
        conv_req.temp      <= cur_ctl[CTL_TEMP];
        conv_req.input_sel <= cur_inp;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result queues
  // ----------------------------------------------------------------
  logic [3:0] pop;
  generate
    for (g = 0; g < NUM_SEQ; g++) begin : g_q
      logic do_push;
      logic full;
      logic empty;
      assign do_push = push && cur_r == 2'(g);
      assign full    = count_r[g] == DEPTH_LAST[g] + 4'h1;
      assign empty   = count_r[g] == 4'h0;
      assign pop[g]  = rd_acc && in_seq && win_seq == 2'(g) && win_sub == SUB_RESULT;

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          head_r[g]  <= '0;
          tail_r[g]  <= '0;
          count_r[g] <= '0;
        end else begin
          if (do_push && !full) begin
            queue_r[g][head_r[g]] <= avg_val;
            head_r[g] <= (4'(head_r[g]) == DEPTH_LAST[g]) ? '0 : head_r[g] + 3'h1;
          end
          if (pop[g] && !empty) begin
            tail_r[g] <= (4'(tail_r[g]) == DEPTH_LAST[g]) ? '0 : tail_r[g] + 3'h1;
          end
          count_r[g] <= count_r[g] + 4'(do_push && !full) - 4'(pop[g] && !empty);
        end
      end

      // sticky overflow and underflow, set beats clear
      // flags on drop and empty read
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          overflow_r[g]  <= 1'b0;
          underflow_r[g] <= 1'b0;
        end else begin
          if (wr_acc && idx == OVERFLOW_IDX && avs_writedata[g]) begin
            overflow_r[g] <= 1'b0;
          end
          if (do_push && full) begin
            overflow_r[g] <= 1'b1;
          end
          if (wr_acc && idx == UNDERFLOW_IDX && avs_writedata[g]) begin
            underflow_r[g] <= 1'b0;
          end
          if (pop[g] && empty) begin
            underflow_r[g] <= 1'b1;
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          raw_irq_r[g] <= 1'b0;
        end else begin
          if (wr_acc && idx == GATED_IRQ_IDX && avs_writedata[g]) begin
            raw_irq_r[g] <= 1'b0;
          end
          if (do_push && cur_ctl[CTL_IRQ]) begin
            raw_irq_r[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      seq_irq <= 4'h0;
    end else begin
      seq_irq <= raw_irq_r & irq_gate_r;
    end
  end

  // ----------------------------------------------------------------
  // Configuration writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_seq_r  <= 4'h0;
      irq_gate_r    <= 4'h0;
      trigger_sel_r <= 16'h0;
      priority_r    <= PRIORITY_RST[15:0];
      avg_r         <= AVG_RST;
      for (int i = 0; i < NUM_SEQ; i++) begin
        input_sel_r[i] <= 32'h0;
        step_ctl_r[i]  <= 32'h0;
      end
    end else if (wr_acc) begin
      unique case (idx)
        ACTIVE_SEQ_IDX: active_seq_r  <= avs_writedata[3:0];
        IRQ_GATE_IDX:   irq_gate_r    <= avs_writedata[3:0];
        TRIG_SEL_IDX:   trigger_sel_r <= avs_writedata[15:0];
        PRIORITY_IDX:   priority_r    <= avs_writedata[15:0] & 16'h3333;
        AVG_CTRL_IDX:   avg_r <= (avs_writedata[2:0] > AVG_MAX_LOG2) ? AVG_MAX_LOG2
                                                                    : avs_writedata[2:0];
        default: begin
          if (in_seq && win_sub == SUB_INPUT_SEL) begin
            input_sel_r[win_seq] <= avs_writedata;
          end
          if (in_seq && win_sub == SUB_STEP_CTL) begin
            step_ctl_r[win_seq] <= avs_writedata;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    if (in_seq) begin
      unique case (win_sub)
        SUB_INPUT_SEL: rd_val = input_sel_r[win_seq];
        SUB_STEP_CTL:  rd_val = step_ctl_r[win_seq];
        SUB_RESULT:    rd_val = 32'(queue_r[win_seq][tail_r[win_seq]]);
        SUB_QUEUE_STATE: begin
          rd_val[QS_TAIL_LSB +: PTR_W] = tail_r[win_seq];
          rd_val[QS_HEAD_LSB +: PTR_W] = head_r[win_seq];
          rd_val[QS_EMPTY] = count_r[win_seq] == 4'h0;
          rd_val[QS_FULL]  = count_r[win_seq] == DEPTH_LAST[win_seq] + 4'h1;
        end
        default: rd_val = 32'h0;
      endcase
    end else begin
      unique case (idx)
        ACTIVE_SEQ_IDX: rd_val = {28'h0, active_seq_r};
        RAW_IRQ_IDX:    rd_val = {28'h0, raw_irq_r};
        IRQ_GATE_IDX:   rd_val = {28'h0, irq_gate_r};
        GATED_IRQ_IDX:  rd_val = {28'h0, raw_irq_r & irq_gate_r};
        OVERFLOW_IDX:   rd_val = {28'h0, overflow_r};
        UNDERFLOW_IDX:  rd_val = {28'h0, underflow_r};
        TRIG_SEL_IDX:   rd_val = {16'h0, trigger_sel_r};
        PRIORITY_IDX:   rd_val = {16'h0, priority_r};
        AVG_CTRL_IDX:   rd_val = {29'h0, avg_r};
        default:        rd_val = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0;
    end else if (rd_acc) begin
      avs_readdata <= rd_val;
    end
  end

endmodule
`default_nettype wire

// [hw/seq_ctrl_pkg.sv]
`default_nettype none
package seq_ctrl_pkg;

  // Sequencer geometry
  localparam int NUM_SEQ   = 4;
  localparam int MAX_STEPS = 8;
  localparam int RES_W     = 10;
  localparam int DATA_W    = 32;
  localparam int PTR_W     = 3;
  localparam int CNT_W     = 4;

  // Register word offsets (byte address = 4 * index)
  localparam logic [5:0] ACTIVE_SEQ_IDX   = 6'h00;
  localparam logic [5:0] RAW_IRQ_IDX      = 6'h01;
  localparam logic [5:0] IRQ_GATE_IDX     = 6'h02;
  localparam logic [5:0] GATED_IRQ_IDX    = 6'h03;
  localparam logic [5:0] OVERFLOW_IDX     = 6'h04;
  localparam logic [5:0] TRIG_SEL_IDX     = 6'h05;
  localparam logic [5:0] UNDERFLOW_IDX    = 6'h06;
  localparam logic [5:0] PRIORITY_IDX     = 6'h08;
  localparam logic [5:0] SW_TRIG_IDX      = 6'h0A;
  localparam logic [5:0] AVG_CTRL_IDX     = 6'h0C;
  localparam logic [5:0] SEQ_BASE_IDX     = 6'h10;
  localparam logic [5:0] SEQ_STRIDE       = 6'h08;
  // Within a sequencer window
  localparam logic [2:0] SUB_INPUT_SEL    = 3'h0;
  localparam logic [2:0] SUB_STEP_CTL     = 3'h1;
  localparam logic [2:0] SUB_RESULT       = 3'h2;
  localparam logic [2:0] SUB_QUEUE_STATE  = 3'h3;

  // Step control nibble fields
  localparam int CTL_DIFF  = 0;
  localparam int CTL_LAST  = 1;
  localparam int CTL_IRQ   = 2;
  localparam int CTL_TEMP  = 3;

  // Queue state fields
  localparam int QS_TAIL_LSB  = 0;
  localparam int QS_HEAD_LSB  = 4;
  localparam int QS_EMPTY     = 8;
  localparam int QS_FULL      = 12;

  // Trigger selection codes (4 bits per sequencer)
  localparam logic [3:0] TRIG_PROCESSOR = 4'h0;
  localparam logic [3:0] TRIG_EXTERNAL  = 4'h1;
  localparam logic [3:0] TRIG_ALWAYS    = 4'hF;

  // Reset values and averaging limit
  localparam logic [31:0] PRIORITY_RST  = 32'h0000_3210;
  localparam logic [2:0]  AVG_RST       = 3'h0;
  localparam logic [2:0]  AVG_MAX_LOG2  = 3'h6;

  // Converter clock enable: 250 MHz / 16.667 MHz target
  localparam int SYS_CLK_KHZ   = 250000;
  localparam int CONV_CLK_KHZ  = 16667;
  localparam int CONV_DIV      = (SYS_CLK_KHZ + CONV_CLK_KHZ - 1) / CONV_CLK_KHZ;
  localparam logic [4:0] CONV_DIV_LAST = 5'(CONV_DIV - 1);

  typedef struct packed {
    logic       diff;
    logic       temp;
    logic [3:0] input_sel;
  } conv_req_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_WAIT
  } run_state_t;

endpackage
`default_nettype wire

// [testbench/conv_core_model.sv]
`default_nettype none
module conv_core_model
  import seq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Request from the block
  input  wire logic             conv_start,
  input  wire conv_req_t        conv_req,
  // Bench control
  input  wire logic             slow,
  // Answer to the block
  output var  logic             conv_done,
  output var  logic [RES_W-1:0] conv_result
);
  timeunit 1ns;
  timeprecision 1ps;

  int         count;
  int         wait_n;
  logic       busy;
  conv_req_t  held;
  logic [3:0] log_sel [0:63];

  // ----------------------------------------
  // Converter core: result valid only in done cycle
  // ----------------------------------------
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    if (srst) begin
      busy        <= 1'b0;
      count       <= 0;
      conv_result <= 10'h2AA;
    end else if (conv_start) begin
      held               <= conv_req;
      busy               <= 1'b1;
      wait_n             <= slow ? 9 : 2;
      log_sel[count[5:0]] <= conv_req.input_sel;
      count              <= count + 1;
      conv_result        <= ~conv_result;
    end else if (busy && wait_n == 0) begin
      conv_done   <= 1'b1;
      conv_result <= {held, 4'h5};
      busy        <= 1'b0;
    end else begin
      wait_n      <= wait_n - 1;
      conv_result <= ~conv_result;
    end
  end
endmodule
`default_nettype wire

// [testbench/adc_sample_sequencer_control_properties.sv]
`default_nettype none
module adc_sample_sequencer_control_checker
  import seq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Register bus
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [31:0]      avs_readdata,
  input  wire logic             avs_waitrequest,
  // Converter and interrupts
  input  wire logic [3:0]       ext_trigger,
  input  wire logic             conv_start,
  input  wire conv_req_t        conv_req,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] conv_result,
  input  wire logic [3:0]       seq_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  logic [4:0] gap_r;

  // ----------------------------------------
  // Cycles since last converter start
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gap_r <= 5'h1F;
    end else if (conv_start) begin
      gap_r <= 5'h01;
    end else if (gap_r != 5'h1F) begin
      gap_r <= gap_r + 5'h01;
    end
  end

  a_pace_gap: assert property (conv_start |-> gap_r >= 5'(CONV_DIV))
    else $error("converter started before pace interval");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait state");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without request");
  a_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data changed without read");
  a_irq_rise: assert property ((seq_irq & ~$past(seq_irq)) != 4'h0 |->
      $past(conv_done) || $past(conv_done, 2) || $past(conv_done, 3) ||
      $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("interrupt line rose without cause");
  a_irq_clear: assert property ((~seq_irq & $past(seq_irq)) != 4'h0 |->
      $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("interrupt line fell without write");
  a_reset_quiet: assert property ($fell(srst) |-> (!conv_start && seq_irq == 4'h0) [*3])
    else $error("activity right after reset");

  c_start: cover property (conv_start);
  c_irq: cover property ($rose(seq_irq[0]));
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule
`default_nettype wire

// [testbench/adc_sample_sequencer_control_bench.sv]
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module adc_sample_sequencer_control_bench;
  import seq_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic             sys_clk = 1'b0;
  logic             srst = 1'b1;
  logic [7:0]       avs_address = 8'h00;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic [3:0]       ext_trigger = 4'h0;
  logic             conv_start;
  conv_req_t        conv_req;
  logic             conv_done;
  logic [RES_W-1:0] conv_result;
  logic [3:0]       seq_irq;
  logic             slow = 1'b0;
  int               num_errors = 0;
  int               total_checks = 0;
  int               cyc = 0;

  always #2 sys_clk = ~sys_clk;

  adc_sample_sequencer_control i_adc_sample_sequencer_control (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_trigger(ext_trigger), .conv_start(conv_start),
    .conv_req(conv_req), .conv_done(conv_done), .conv_result(conv_result), .seq_irq(seq_irq));

  conv_core_model i_conv_core_model (
    .sys_clk(sys_clk), .srst(srst), .conv_start(conv_start), .conv_req(conv_req),
    .slow(slow), .conv_done(conv_done), .conv_result(conv_result));

  function automatic logic [5:0] sidx(input int n, input logic [2:0] sub);
    return SEQ_BASE_IDX + SEQ_STRIDE * 6'(n) + 6'(sub);
  endfunction

  task automatic results;
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end

  // ----------------------------------------
  // Avalon-MM master
  // ----------------------------------------
  task automatic bus_wr(input logic [5:0] idx, input logic [31:0] d);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic bus_rd(input logic [5:0] idx, output logic [31:0] d);
    avs_address <= {idx, 2'b00};
    avs_read    <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wait_count(input int target);
    while (i_conv_core_model.count < target) @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values;
    logic [31:0] d;
    bus_rd(PRIORITY_IDX, d); `CHK(d, PRIORITY_RST)
    bus_rd(AVG_CTRL_IDX, d); `CHK(d, 32'(AVG_RST))
    bus_rd(ACTIVE_SEQ_IDX, d); `CHK(d, 32'h0000_0000)
    bus_rd(sidx(0, SUB_QUEUE_STATE), d); `CHK(d, 32'h0000_0100)
    bus_wr(6'h07, 32'hFFFF_FFFF);
    bus_rd(6'h07, d); `CHK(d, 32'h0000_0000)
  endtask

  task automatic t_seq_zero;
    logic [31:0] d;
    logic [3:0]  s;
    int          c;
    bus_wr(TRIG_SEL_IDX, 32'h0000_0000);
    bus_wr(sidx(0, SUB_INPUT_SEL), 32'h0003_3211);
    bus_wr(sidx(0, SUB_STEP_CTL), 32'h0006_0040);
    bus_wr(ACTIVE_SEQ_IDX, 32'h0000_0001);
    c = i_conv_core_model.count;
    bus_wr(SW_TRIG_IDX, 32'h0000_0001);
    wait_count(c + 5);
    repeat (60) @(posedge sys_clk);
    `CHK(i_conv_core_model.count, c + 5)
    for (int k = 0; k < 5; k++) begin
      s = 4'(32'h0003_3211 >> (4 * k));
      `CHK(i_conv_core_model.log_sel[c + k], s)
    end
    bus_rd(sidx(0, SUB_QUEUE_STATE), d); `CHK(d, 32'h0000_0050)
    bus_rd(RAW_IRQ_IDX, d); `CHK(d, 32'h0000_0001)
    for (int k = 0; k < 5; k++) begin
      s = 4'(32'h0003_3211 >> (4 * k));
      bus_rd(sidx(0, SUB_RESULT), d); `CHK(d, {24'h0, s, 4'h5})
    end
    bus_rd(sidx(0, SUB_RESULT), d);
    bus_rd(UNDERFLOW_IDX, d); `CHK(d, 32'h0000_0001)
    bus_wr(UNDERFLOW_IDX, 32'h0000_0001);
    bus_rd(UNDERFLOW_IDX, d); `CHK(d, 32'h0000_0000)
    bus_rd(sidx(0, SUB_QUEUE_STATE), d); `CHK(d, 32'h0000_0155)
  endtask

  task automatic t_irq;
    logic [31:0] d;
    bus_wr(IRQ_GATE_IDX, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    `CHK(seq_irq, 4'h1)
    bus_rd(GATED_IRQ_IDX, d); `CHK(d, 32'h0000_0001)
    bus_wr(GATED_IRQ_IDX, 32'h0000_0000);
    bus_rd(RAW_IRQ_IDX, d); `CHK(d, 32'h0000_0001)
    bus_wr(GATED_IRQ_IDX, 32'h0000_0001);
    bus_rd(RAW_IRQ_IDX, d); `CHK(d, 32'h0000_0000)
    repeat (3) @(posedge sys_clk);
    `CHK(seq_irq, 4'h0)
  endtask

  task automatic t_priority;
    logic [31:0] d;
    int          c;
    // distinct priorities, sequencer 2 above sequencer 1
    bus_wr(PRIORITY_IDX, 32'h0000_3012);
    bus_wr(sidx(1, SUB_INPUT_SEL), 32'h0000_0004);
    bus_wr(sidx(1, SUB_STEP_CTL), 32'h0000_0002);
    bus_wr(sidx(2, SUB_INPUT_SEL), 32'h0000_0006);
    bus_wr(sidx(2, SUB_STEP_CTL), 32'h0000_0002);
    bus_wr(ACTIVE_SEQ_IDX, 32'h0000_0006);
    c = i_conv_core_model.count;
    bus_wr(SW_TRIG_IDX, 32'h0000_0006);
    wait_count(c + 2);
    `CHK(i_conv_core_model.log_sel[c], 4'h6)
    `CHK(i_conv_core_model.log_sel[c + 1], 4'h4)
    repeat (40) @(posedge sys_clk);
    bus_rd(sidx(2, SUB_RESULT), d); `CHK(d, 32'h0000_0065)
    bus_rd(sidx(1, SUB_RESULT), d); `CHK(d, 32'h0000_0045)
    // One pin edge, two-sample averaging
    bus_wr(TRIG_SEL_IDX, 32'h0000_0010);
    bus_wr(AVG_CTRL_IDX, 32'h0000_0001);
    c = i_conv_core_model.count;
    ext_trigger <= 4'h2;
    repeat (4) @(posedge sys_clk);
    ext_trigger <= 4'h0;
    repeat (80) @(posedge sys_clk);
    `CHK(i_conv_core_model.count, c + 2)
    `CHK(i_conv_core_model.log_sel[c + 1], 4'h4)
    bus_rd(sidx(1, SUB_RESULT), d); `CHK(d, 32'h0000_0045)
    bus_wr(AVG_CTRL_IDX, 32'h0000_0000);
  endtask

  task automatic t_overflow;
    logic [31:0] d;
    int          c;
    slow <= 1'b1;
    bus_wr(sidx(3, SUB_INPUT_SEL), 32'h0000_0007);
    bus_wr(sidx(3, SUB_STEP_CTL), 32'h0000_0002);
    // continuous trigger only on the lowest priority
    bus_wr(TRIG_SEL_IDX, 32'h0000_F000);
    c = i_conv_core_model.count;
    repeat (40) @(posedge sys_clk);
    `CHK(i_conv_core_model.count, c)
    bus_wr(ACTIVE_SEQ_IDX, 32'h0000_0008);
    d = 32'h0;
    while (d[3] !== 1'b1) bus_rd(OVERFLOW_IDX, d);
    bus_wr(ACTIVE_SEQ_IDX, 32'h0000_0000);
    repeat (30) @(posedge sys_clk);
    bus_rd(sidx(3, SUB_QUEUE_STATE), d); `CHK(d[QS_FULL], 1'b1)
    bus_rd(sidx(3, SUB_RESULT), d); `CHK(d, 32'h0000_0075)
    bus_rd(OVERFLOW_IDX, d); `CHK(d, 32'h0000_0008)
    bus_wr(OVERFLOW_IDX, 32'h0000_0008);
    bus_rd(OVERFLOW_IDX, d); `CHK(d, 32'h0000_0000)
    slow <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_reset_values();
    t_seq_zero();
    t_irq();
    t_priority();
    t_overflow();
    results();
  end
endmodule

bind adc_sample_sequencer_control adc_sample_sequencer_control_checker i_checker (
  .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ext_trigger(ext_trigger), .conv_start(conv_start),
  .conv_req(conv_req), .conv_done(conv_done), .conv_result(conv_result), .seq_irq(seq_irq));
`default_nettype wire
